// >>> pkg/mtc_pkg.sv
// Constants and types of the measurement trigger cascade block
package mtc_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 50;
    localparam int STEP_NS = 10000;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_US = STEP_NS / 1000;
    localparam int RATE_HZ = 100;
    localparam int PERIOD_US = 1000000 / RATE_HZ;
    localparam int PERIOD_STEPS = PERIOD_US / STEP_US;
    localparam int MIN_TRIG_US = 10000;
    localparam int HOLDOFF_STEPS = (MIN_TRIG_US + STEP_US - 1) / STEP_US;
    localparam int CASC_HIGH_US = 100;
    localparam int CASC_STEPS = (CASC_HIGH_US + STEP_US - 1) / STEP_US;
    // ==========================================================
    // Parameter sets
    localparam int NUM_SETS = 16;
    localparam int SET_AW = 4;
    localparam int SET_W = 28;
    localparam int SET_MODE = 0;
    localparam int SET_REGARD = 1;
    localparam int SET_CASC = 2;
    localparam int SET_EXP_LSB = 8;
    localparam int SET_FOV_LSB = 16;
    // Continuous, disregard, no cascade, 50 steps exposure, full view
    localparam logic [27:0] SET_RESET = 28'hfff3200;
    // ==========================================================
    // Register map
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SET_IDX = 12'h004;
    localparam logic [11:0] OFS_SET_DATA = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam int CTRL_NET_ACT = 0;
    localparam int CTRL_NET_TRIG = 1;
    localparam int CTRL_SEL_LSB = 4;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        MTC_IDLE = 3'b001,
        MTC_EXPOSE = 3'b010,
        MTC_CASC = 3'b100
    } mtc_state_t;
endpackage : mtc_pkg

// >>> pkg/mtc_mem_if.sv
// Port bundle between the sequencer and its parameter set store
`timescale 1ns/1ns
interface mtc_mem_if;
    import mtc_pkg::*;
    logic we;
    logic [SET_AW-1:0] waddr;
    logic [SET_W-1:0] wdata;
    logic [SET_AW-1:0] raddr;
    logic [SET_W-1:0] rdata;
    modport ctl(output we, output waddr, output wdata, output raddr, input rdata);
    modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mtc_mem_if

// >>> hw/mtc_param_mem.sv
// Store of the sixteen inspection parameter sets
`timescale 1ns/1ns
module mtc_param_mem
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    mtc_mem_if.mem port
);
    logic [SET_W-1:0] words [NUM_SETS];

    // Reset to factory defaults so every set starts out usable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SETS; i++) begin
                words[i] <= SET_RESET;
            end
            port.rdata <= SET_RESET;
        end else begin
            if (port.we) begin
                words[port.waddr] <= port.wdata;
            end
            port.rdata <= words[port.raddr];
        end
    end
endmodule : mtc_param_mem

// >>> hw/mtc_top.sv
// Measurement sequencer: activation gate, trigger, cascade, set select
//
// Behaviour
// - Factory default ignores both activation sources; measuring stays enabled.
// - With regard set, measure only while pin or network activation is active.
// - Show a waiting-for-activation indication while held off.
// - Continuous mode measures at 100 Hz and sends every result unasked.
// - Triggered mode measures once per pin or network trigger.
// - The pin trigger starts on its rising edge.
// - Default mode continuous; pin only works in triggered mode; each mode shown.
// - Cascade output signals own exposure complete, starting the next sensor.
// - A cascade chain holds at most six sensors.
// - Sixteen sets hold mode, activation, cascade, exposure and view range.
// - Active set chosen by software, network or local panel.
// - Activation off switches laser and transmission off, on again likewise.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module mtc_top
    import mtc_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic activation_input,
    input wire logic trigger_input,
    input wire logic [3:0] panel_task_sel,
    input wire logic panel_task_load,
    output logic laser_enable,
    output logic result_tx_enable,
    output logic exposure_active,
    output logic result_valid,
    output logic cascade_output,
    output logic continuous_mode_indication,
    output logic triggered_mode_indication,
    output logic waiting_activation_indication,
    output logic [11:0] field_of_view
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction : hit

    // ==========================================================
    // Pin synchronisers
    logic act_s1, act_s2, trig_s1, trig_s2, trig_s3;
    logic load_s1, load_s2, load_s3;
    logic [3:0] panel_s1, panel_s2;
    logic trig_rise, panel_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {act_s2, act_s1} <= 2'h0;
            {trig_s3, trig_s2, trig_s1} <= 3'h0;
            {load_s3, load_s2, load_s1} <= 3'h0;
            {panel_s2, panel_s1} <= 8'h00;
        end else begin
            {act_s2, act_s1} <= {act_s1, activation_input};
            {trig_s3, trig_s2, trig_s1} <= {trig_s2, trig_s1, trigger_input};
            {load_s3, load_s2, load_s1} <= {load_s2, load_s1, panel_task_load};
            {panel_s2, panel_s1} <= {panel_s1, panel_task_sel};
        end
    end

    assign trig_rise = trig_s2 & ~trig_s3;
    assign panel_rise = load_s2 & ~load_s3;

    // ==========================================================
    // APB slave
    mtc_mem_if mif();
    logic ph;
    logic acc, done, wr_done;
    logic hit_ctrl, hit_idx, hit_data, hit_stat, map_hit;
    logic net_act, net_trig;
    logic [3:0] act_idx, set_idx;
    logic [15:0] result_cnt;
    logic [31:0] rd_value;

    assign acc = psel & penable;
    assign done = acc & pready;
    assign wr_done = done & pwrite;
    assign hit_ctrl = hit(paddr, OFS_CTRL);
    assign hit_idx = hit(paddr, OFS_SET_IDX);
    assign hit_data = hit(paddr, OFS_SET_DATA);
    assign hit_stat = hit(paddr, OFS_STATUS);
    assign map_hit = hit_ctrl | hit_idx | hit_data | hit_stat;
    assign net_trig = wr_done & hit_ctrl & pwdata[CTRL_NET_TRIG];

    assign rd_value = hit_ctrl ? {24'h000000, act_idx, 3'h0, net_act} :
                      hit_idx ? {28'h0000000, set_idx} :
                      hit_data ? {4'h0, mif.rdata} :
                      hit_stat ? {result_cnt, 4'h0, act_idx, 3'h0, cascade_output,
                                  exposure_active, triggered_mode_indication,
                                  waiting_activation_indication, laser_enable} :
                      32'h00000000;

    // Two wait cycles so the set store read is registered before reply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (done) begin
            ph <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (acc && ph) begin
            pready <= 1'b1;
            pslverr <= ~map_hit;
            prdata <= pwrite ? 32'h00000000 : rd_value;
        end else if (acc) begin
            ph <= 1'b1;
        end
    end

    // ==========================================================
    // Software registers and set selection
    logic load_set, load_pend, issue, load_go;
    logic cfg_mode, cfg_regard, cfg_casc;
    logic [7:0] cfg_exp;

    assign load_set = (wr_done & hit_ctrl) | (wr_done & hit_data & (set_idx == act_idx)) | panel_rise;
    assign issue = load_pend & ~psel;
    assign mif.we = wr_done & hit_data;
    assign mif.waddr = set_idx;
    assign mif.wdata = pwdata[SET_W-1:0];
    assign mif.raddr = psel ? set_idx : act_idx;

    mtc_param_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .port(mif.mem)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            net_act <= 1'b0;
            set_idx <= 4'h0;
            act_idx <= 4'h0;
        end else if (wr_done) begin
            if (hit_ctrl) net_act <= pwdata[CTRL_NET_ACT];
            if (hit_ctrl) act_idx <= pwdata[CTRL_SEL_LSB +: 4];
            if (hit_idx) set_idx <= pwdata[3:0];
        end else if (panel_rise) begin
            act_idx <= panel_s2;
        end
    end

    // New request wins over the one being issued
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pend <= 1'b0;
            load_go <= 1'b0;
        end else begin
            load_pend <= load_set | (load_pend & ~issue);
            load_go <= issue;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_mode <= SET_RESET[SET_MODE];
            cfg_regard <= SET_RESET[SET_REGARD];
            cfg_casc <= SET_RESET[SET_CASC];
            cfg_exp <= SET_RESET[SET_EXP_LSB +: 8];
            field_of_view <= SET_RESET[SET_FOV_LSB +: 12];
        end else if (load_go) begin
            cfg_mode <= mif.rdata[SET_MODE];
            cfg_regard <= mif.rdata[SET_REGARD];
            cfg_casc <= mif.rdata[SET_CASC];
            cfg_exp <= mif.rdata[SET_EXP_LSB +: 8];
            field_of_view <= mif.rdata[SET_FOV_LSB +: 12];
        end
    end

    // ==========================================================
    // Activation gate and indications
    logic next_gate;

    assign next_gate = ~cfg_regard | act_s2 | net_act;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            laser_enable <= 1'b1;
            result_tx_enable <= 1'b1;
            waiting_activation_indication <= 1'b0;
            continuous_mode_indication <= 1'b1;
            triggered_mode_indication <= 1'b0;
        end else begin
            laser_enable <= next_gate;
            result_tx_enable <= next_gate;
            waiting_activation_indication <= ~next_gate;
            continuous_mode_indication <= ~cfg_mode;
            triggered_mode_indication <= cfg_mode;
        end
    end

    // ==========================================================
    // Step divider, rate and holdoff
    mtc_state_t state, next_state;
    logic [15:0] div_cnt;
    logic [10:0] since_cnt;
    logic [7:0] step_cnt, exp_len;
    logic step, hold_done, trig_ev, start, exp_end, casc_end;

    assign step = div_cnt == 16'(STEP_CYCLES - 1);
    // Rate period and trigger holdoff are equal, one counter serves both
    // Final step of a period counts too, keeping the 100 Hz period exact
    assign hold_done = (since_cnt == 11'(HOLDOFF_STEPS))
                       | (step & (since_cnt == 11'(HOLDOFF_STEPS - 1)));
    assign trig_ev = cfg_mode & (trig_rise | net_trig);
    assign start = (state == MTC_IDLE) & laser_enable & hold_done & (~cfg_mode | trig_ev);
    assign exp_len = (cfg_exp == 8'h00) ? 8'h01 : cfg_exp;
    assign exp_end = (state == MTC_EXPOSE) & step & (step_cnt == exp_len - 8'h01);
    assign casc_end = (state == MTC_CASC) & step & (step_cnt == 8'(CASC_STEPS - 1));

    // Divider restarts with each measurement so steps align to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            since_cnt <= 11'(HOLDOFF_STEPS);
        end else begin
            div_cnt <= (start | step) ? 16'h0000 : div_cnt + 16'h0001;
            if (start) since_cnt <= 11'h000;
            else if (step && since_cnt != 11'(HOLDOFF_STEPS)) since_cnt <= since_cnt + 11'h001;
        end
    end

    // ==========================================================
    // Exposure and cascade sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            MTC_IDLE: if (start) next_state = MTC_EXPOSE;
            MTC_EXPOSE: if (exp_end) next_state = cfg_casc ? MTC_CASC : MTC_IDLE;
            MTC_CASC: if (casc_end) next_state = MTC_IDLE;
            default: next_state = MTC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MTC_IDLE;
            step_cnt <= 8'h00;
            exposure_active <= 1'b0;
            result_valid <= 1'b0;
            cascade_output <= 1'b0;
            result_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            step_cnt <= (start | exp_end | casc_end) ? 8'h00 : step_cnt + {7'h00, step};
            result_valid <= exp_end & laser_enable;
            if (start) exposure_active <= 1'b1;
            if (exp_end) exposure_active <= 1'b0;
            // Pulse far shorter than a period; chain depth bounded outside
            if (exp_end) cascade_output <= cfg_casc;
            if (casc_end) cascade_output <= 1'b0;
            if (exp_end && laser_enable) result_cnt <= result_cnt + 16'h0001;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence exp_done_s;
        exposure_active ##1 !exposure_active;
    endsequence

    gate_disregard_a: assert property (!cfg_regard |=> laser_enable)
        else $error("gate closed while activation disregarded");
    start_gated_a: assert property (start |-> laser_enable && (act_s2 || net_act || !cfg_regard))
        else $error("measurement started with gate closed");
    wait_ind_a: assert property (cfg_regard && !act_s2 && !net_act |=> waiting_activation_indication)
        else $error("waiting indication missing");
    result_sent_a: assert property (exp_done_s ##0 $past(laser_enable) |-> result_valid)
        else $error("result not sent after exposure");
    trig_start_a: assert property (start && cfg_mode |-> trig_ev)
        else $error("triggered start without trigger");
    edge_start_a: assert property (cfg_mode && trig_rise && laser_enable && hold_done
                                   && state == MTC_IDLE |=> exposure_active)
        else $error("rising trigger edge not served");
    mode_ind_a: assert property (cfg_mode |=> triggered_mode_indication && !continuous_mode_indication)
        else $error("mode indication wrong");
    casc_after_a: assert property (exp_done_s |-> cascade_output == $past(cfg_casc))
        else $error("cascade output not raised at exposure end");
    early_drop_a: assert property (!exposure_active && trig_ev && !(laser_enable && hold_done)
                                   |=> !exposure_active)
        else $error("ignored trigger started a measurement");
    laser_off_a: assert property (!next_gate |=> !laser_enable ##0 !result_tx_enable)
        else $error("laser or transmission left on");
endmodule : mtc_top

// >>> test/mtc_partner.sv
// Behavioural model of the controller that drives the activation and trigger pins
`timescale 1ns/1ns
module mtc_partner #(
    parameter int STEP = 2
) (
    input wire logic pclk,
    input wire logic act_req,
    input wire logic trig_req,
    input wire logic early,
    output logic activation_input,
    output logic trigger_input,
    output logic busy
);
    // ==========================================================
    // Pin timing, scaled to the design step
    localparam int HIGH_CYC = 10 * STEP;
    localparam int LOW_CYC = 100 * STEP;
    localparam int GAP_CYC = 1000 * STEP;
    localparam int LEAD_CYC = 10 * STEP;
    int cyc = 0;
    int act_age = 0;
    int last_edge = -GAP_CYC;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        activation_input <= act_req;
        act_age <= act_req ? act_age + 1 : 0;
    end
    // ==========================================================
    // Pulse generator; early edges only when the bench asks for a refusal
    initial begin
        trigger_input = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (trig_req) begin
                busy <= 1'b1;
                while (!(early || cyc - last_edge >= GAP_CYC) || (act_req && act_age < LEAD_CYC)) begin
                    @(posedge pclk);
                end
                trigger_input <= 1'b1;
                last_edge = cyc;
                repeat (HIGH_CYC) @(posedge pclk);
                trigger_input <= 1'b0;
                repeat (LOW_CYC) @(posedge pclk);
                busy <= 1'b0;
            end
        end
    end
endmodule : mtc_partner

// >>> test/tb.sv
// Self-checking bench of the measurement trigger cascade block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
    import mtc_pkg::*;
    localparam int SC = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, tp;
    logic [11:0] paddr, field_of_view, fov;
    logic [31:0] pwdata, prdata, rd;
    logic act_req, trig_req, early, act_pin, trig_pin, busy;
    logic [3:0] panel_task_sel;
    logic panel_task_load, laser_enable, result_tx_enable, exposure_active, result_valid, cascade_output;
    logic cont_ind, trig_ind, wait_ind;
    logic [7:0] seed, ex;
    int err_count, n_compared, cyc, n_res, n_exp, res_at, res_gap, exp_run, exp_len, casc_run, casc_len;
    int trig_at, lat, n0;

    mtc_top #(.STEP_CYCLES(SC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .activation_input(act_pin),
        .trigger_input(trig_pin), .panel_task_sel(panel_task_sel), .panel_task_load(panel_task_load),
        .laser_enable(laser_enable), .result_tx_enable(result_tx_enable), .exposure_active(exposure_active),
        .result_valid(result_valid), .cascade_output(cascade_output), .continuous_mode_indication(cont_ind),
        .triggered_mode_indication(trig_ind), .waiting_activation_indication(wait_ind),
        .field_of_view(field_of_view)
    );
    mtc_partner #(.STEP(SC)) u_partner (
        .pclk(pclk), .act_req(act_req), .trig_req(trig_req), .early(early), .activation_input(act_pin),
        .trigger_input(trig_pin), .busy(busy)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ==========================================================
    // Monitor: pulse counts, run lengths, trigger latency
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        tp <= trig_pin;
        if (trig_pin === 1'b1 && tp !== 1'b1) trig_at <= cyc;
        if (result_valid === 1'b1) begin
            n_res <= n_res + 1;
            res_gap <= cyc - res_at;
            res_at <= cyc;
        end
        exp_run <= (exposure_active === 1'b1) ? exp_run + 1 : 0;
        if (exposure_active !== 1'b1 && exp_run != 0) exp_len <= exp_run;
        if (exposure_active === 1'b1 && exp_run == 0) begin
            n_exp <= n_exp + 1;
            lat <= cyc - trig_at;
        end
        casc_run <= (cascade_output === 1'b1) ? casc_run + 1 : 0;
        if (cascade_output !== 1'b1 && casc_run != 0) casc_len <= casc_run;
    end
    // ==========================================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Set word: view range, exposure steps, then cascade, regard and mode flags
    function automatic logic [31:0] set_word(input logic [11:0] v, input logic [7:0] e, input logic [2:0] f);
        return {4'h0, v, e, 5'h00, f};
    endfunction : set_word
    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic stall;
        err_count++;
        summarize();
    endtask : stall
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) stall();
    endtask : apb
    // Slow partner may wait out the full edge spacing
    task automatic pulse(input logic quick);
        int n;
        n = 0;
        early <= quick;
        trig_req <= 1'b1;
        @(posedge pclk);
        trig_req <= 1'b0;
        @(posedge pclk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000) stall();
    endtask : pulse
    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        act_req = 1'b0;
        trig_req = 1'b0;
        early = 1'b0;
        panel_task_sel = 4'h0;
        panel_task_load = 1'b0;
        seed = 8'h52;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        settle(4500);
        `CHK(n_res >= 2, 1'b1)
        `CHK(res_gap, 1000 * SC)
        `CHK(exp_len, 50 * SC)
        `CHK({laser_enable, result_tx_enable, wait_ind, cont_ind, trig_ind}, 5'b11010)
        `CHK(field_of_view, 12'hfff)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK({rd[11:8], rd[2:0]}, 7'h01)
        seed = lfsr(seed);
        ex = {4'h0, seed[3:0]} + 8'h01;
        seed = lfsr(seed);
        fov = {seed, seed[7:4] ^ 4'ha};
        apb(1'b1, OFS_SET_IDX, 32'h3);
        apb(1'b1, OFS_SET_DATA, set_word(fov, ex, 3'h7));
        apb(1'b0, OFS_SET_DATA, 32'h0);
        `CHK(rd, set_word(fov, ex, 3'h7))
        apb(1'b1, OFS_CTRL, 32'h30);
        settle(4);
        `CHK({trig_ind, cont_ind, wait_ind, laser_enable, result_tx_enable}, 5'b10100)
        `CHK(field_of_view, fov)
        n0 = n_exp;
        pulse(1'b0);
        `CHK(n_exp, n0)
        act_req <= 1'b1;
        settle(5);
        `CHK({laser_enable, result_tx_enable, wait_ind}, 3'b110)
        pulse(1'b0);
        `CHK(n_exp, n0 + 1)
        `CHK(lat, 3)
        `CHK(exp_len, ex * SC)
        `CHK(casc_len, 10 * SC)
        n0 = n_exp;
        pulse(1'b1);
        `CHK(n_exp, n0)
        act_req <= 1'b0;
        settle(2000);
        apb(1'b1, OFS_CTRL, 32'h31);
        settle(5);
        `CHK(laser_enable, 1'b1)
        apb(1'b1, OFS_CTRL, 32'h33);
        settle(ex * SC + 40);
        `CHK(n_exp, n0 + 1)
        apb(1'b1, OFS_CTRL, 32'h30);
        apb(1'b1, OFS_SET_IDX, 32'h7);
        apb(1'b1, OFS_SET_DATA, set_word(~fov, 8'h01, 3'h0));
        panel_task_sel <= 4'h7;
        settle(4);
        panel_task_load <= 1'b1;
        settle(10);
        `CHK(field_of_view, ~fov)
        `CHK({cont_ind, laser_enable, wait_ind}, 3'b110)
        summarize();
    end
endmodule : tb
